/* core/error_mask_alarm_defs.vh */
// register map, field positions and timing constants of the error mask and alarm block
`ifndef ERROR_MASK_ALARM_DEFS_VH
`define ERROR_MASK_ALARM_DEFS_VH
`define ALARM_EVENT_MASK_ADDR 8'h54
`define ALARM_PIN_CONFIG_ADDR 8'h55
`define SHUTDOWN_EVENT_MASK_ADDR 8'h56
`define LOG_MASK_LOW_PULLUP_ADDR 8'h57
`define LOG_MASK_HIGH_ADDR 8'h58
`define POLARITY_SEL_BIT 2
`define HOLD_TIME_LSB 3
`define HOLD_TIME_MSB 5
`define PULLUP_EN_BIT 2
`define LOG_LOW_LSB 4
`define LOG_LOW_MSB 7
`define LOG_HIGH_LSB 0
`define LOG_HIGH_MSB 2
`define REACT_SEL_BIT 6
`define EV_CONFIG 6
`define EV_OVERTEMP 5
`define EV_EXTERNAL 4
`define EV_CTRL_MAX 3
`define EV_CTRL_MIN 2
`define EV_CLIP 1
`define EV_LOSS 0
`define REG_RESET 8'h00
`define CLK_HZ 250000000
`define HOLD_STEP_US 12500
`define HOLD_STEP_CYCLES ((`CLK_HZ / 1000000) * `HOLD_STEP_US)
`endif

/* core/error_mask_alarm.v */
// error event masking, alarm pin, driver shutdown and logging latch
// Function
// RULE_01 - seven error events on bits 6 to 0 are detected
// RULE_02 - alarm mask events change the alarm pin; unmasked events do not
// RULE_03 - shutdown mask events drop aux to 5 mA, tristate drivers and alarm pin
// RULE_04 - logging mask from 0x58[2:0] and 0x57[7:4] latches events
// RULE_05 - shutdown mask bit 6 keeps drivers off on config error across power cycles
// RULE_06 - observer should use high-active polarity to see configuration errors
// RULE_07 - poor amplitude from excessive input or clipping also raises loss of signal
// RULE_08 - open-drain alarm output with selectable polarity and hold time
// RULE_09 - polarity 0 pulls low on error; polarity 1 pulls low without error
// RULE_10 - external low on alarm pin is the external error, polarity 0 only
// RULE_11 - with polarity 0 the alarm pin is disabled during shutdown
// RULE_12 - alarm held at least hold code times 12.5 ms
// RULE_13 - pull-up enable bit turns the internal pull-up on
// RULE_14 - reactivation select 0 recovers when errors clear, 1 only after power cycle
// RULE_15 - alarm stays until error cleared and hold time elapsed
// RULE_16 - enabled events are ORed per output function
`include "error_mask_alarm_defs.vh"
module error_mask_alarm #(
    parameter HOLD_STEP_CYCLES = `HOLD_STEP_CYCLES
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire reg_wr_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    output reg [7:0] reg_rdata_out,
    input wire config_err_in,
    input wire overtemp_in,
    input wire ctrl_max_in,
    input wire ctrl_min_in,
    input wire clip_in,
    input wire loss_in,
    input wire excess_input_in,
    input wire config_err_stored_in,
    input wire alarm_pin_in,
    output wire alarm_pin_out,
    output wire alarm_pin_oe_out,
    output wire alarm_pullup_en_out,
    output wire driver_enable_out,
    output wire aux_low_range_out,
    output wire [6:0] log_latch_out,
    output wire [6:0] event_out,
    output wire alarm_active_out
);
    //------------------------------------------------------------
    // registers
    //------------------------------------------------------------
    reg [7:0] alarm_event_mask_ff;
    reg [7:0] alarm_pin_config_ff;
    reg [7:0] shutdown_event_mask_ff;
    reg [7:0] log_mask_low_pullup_ff;
    reg [7:0] log_mask_high_ff;

    // one write strobe per mapped byte; other addresses are ignored
    wire wr_alarm_mask = reg_wr_in & (reg_addr_in == `ALARM_EVENT_MASK_ADDR);
    wire wr_pin_config = reg_wr_in & (reg_addr_in == `ALARM_PIN_CONFIG_ADDR);
    wire wr_shutdown_mask = reg_wr_in & (reg_addr_in == `SHUTDOWN_EVENT_MASK_ADDR);
    wire wr_log_low = reg_wr_in & (reg_addr_in == `LOG_MASK_LOW_PULLUP_ADDR);
    wire wr_log_high = reg_wr_in & (reg_addr_in == `LOG_MASK_HIGH_ADDR);

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            alarm_event_mask_ff <= `REG_RESET;
        end else if (wr_alarm_mask) begin
            alarm_event_mask_ff <= reg_wdata_in; // [RULE_02]
        end
    end

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            alarm_pin_config_ff <= `REG_RESET;
        end else if (wr_pin_config) begin
            alarm_pin_config_ff <= reg_wdata_in; // [RULE_09] [RULE_12]
        end
    end

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            shutdown_event_mask_ff <= `REG_RESET;
        end else if (wr_shutdown_mask) begin
            shutdown_event_mask_ff <= reg_wdata_in; // [RULE_03]
        end
    end

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            log_mask_low_pullup_ff <= `REG_RESET;
        end else if (wr_log_low) begin
            log_mask_low_pullup_ff <= reg_wdata_in; // [RULE_04] [RULE_13]
        end
    end

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            log_mask_high_ff <= `REG_RESET;
        end else if (wr_log_high) begin
            log_mask_high_ff <= reg_wdata_in; // [RULE_04] [RULE_14]
        end
    end

    //------------------------------------------------------------
    // register fields
    //------------------------------------------------------------
    wire [6:0] alarm_event_mask = alarm_event_mask_ff[6:0];
    wire [6:0] shutdown_event_mask = shutdown_event_mask_ff[6:0];
    wire [2:0] log_mask_upper = log_mask_high_ff[`LOG_HIGH_MSB:`LOG_HIGH_LSB];
    wire [3:0] log_mask_lower = log_mask_low_pullup_ff[`LOG_LOW_MSB:`LOG_LOW_LSB];
    wire [6:0] log_event_mask = {log_mask_upper, log_mask_lower}; // [RULE_04]
    wire alarm_polarity_sel = alarm_pin_config_ff[`POLARITY_SEL_BIT];
    wire [2:0] alarm_hold_time = alarm_pin_config_ff[`HOLD_TIME_MSB:`HOLD_TIME_LSB];
    wire driver_reactivation_sel = log_mask_high_ff[`REACT_SEL_BIT];

    //------------------------------------------------------------
    // event collection
    //------------------------------------------------------------
    // alarm state codes
    localparam [0:0] ALARM_OFF = 1'b0;
    localparam [0:0] ALARM_ON = 1'b1;

    reg [6:0] event_ff;
    reg shutdown_ff;
    reg nxt_shutdown;
    reg [6:0] log_latch_ff;
    reg alarm_ff;
    reg nxt_alarm;
    reg [2:0] hold_steps_ff;
    reg [2:0] nxt_hold_steps;
    reg [31:0] tick_cnt_ff;
    reg [31:0] nxt_tick_cnt;
    reg [7:0] nxt_reg_rdata;

    //------------------------------------------------------------
    // external error input and event sources
    //------------------------------------------------------------
    // the external error is only read while this end leaves the pin released
    wire ext_err = ~alarm_polarity_sel & ~alarm_pin_oe_out & ~alarm_pin_in; // [RULE_10]

    reg [6:0] nxt_event;
    always @* begin
        nxt_event = 7'h00;
        nxt_event[`EV_CONFIG] = config_err_in; // [RULE_01]
        nxt_event[`EV_OVERTEMP] = overtemp_in;
        nxt_event[`EV_EXTERNAL] = ext_err;
        nxt_event[`EV_CTRL_MAX] = ctrl_max_in;
        nxt_event[`EV_CTRL_MIN] = ctrl_min_in;
        nxt_event[`EV_CLIP] = clip_in;
        nxt_event[`EV_LOSS] = loss_in | excess_input_in | clip_in; // [RULE_07]
    end

    //------------------------------------------------------------
    // mask combination
    //------------------------------------------------------------
    wire any_alarm = |(event_ff & alarm_event_mask); // [RULE_02] [RULE_16]
    wire any_shutdown = |(event_ff & shutdown_event_mask); // [RULE_16]
    // stored config error with mask bit 6 keeps drivers off after power-up
    wire sticky_cfg = shutdown_event_mask[`EV_CONFIG] & config_err_stored_in; // [RULE_05]

    //------------------------------------------------------------
    // hold step timer
    //------------------------------------------------------------
    // last count of one hold step, cut to the counter width
    localparam [31:0] TICK_LAST = HOLD_STEP_CYCLES - 1;
    wire tick = (tick_cnt_ff == TICK_LAST);
    wire hold_done = (hold_steps_ff == 3'h0);

    //------------------------------------------------------------
    // event register
    //------------------------------------------------------------
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            event_ff <= 7'h00;
        end else begin
            event_ff <= nxt_event; // [RULE_01]
        end
    end

    //------------------------------------------------------------
    // logging latch
    //------------------------------------------------------------
    // logging bits are sticky; only reset clears them
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            log_latch_ff <= 7'h00;
        end else begin
            log_latch_ff <= log_latch_ff | (event_ff & log_event_mask); // [RULE_04] [RULE_16]
        end
    end

    //------------------------------------------------------------
    // driver shutdown
    //------------------------------------------------------------
    always @* begin
        nxt_shutdown = shutdown_ff;
        if (any_shutdown | sticky_cfg) begin
            nxt_shutdown = 1'b1; // [RULE_03]
        end else if (~driver_reactivation_sel) begin
            nxt_shutdown = 1'b0; // [RULE_14]
        end
    end

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            shutdown_ff <= 1'b0;
        end else begin
            shutdown_ff <= nxt_shutdown;
        end
    end

    //------------------------------------------------------------
    // alarm state with minimum indication time
    //------------------------------------------------------------
    // a fresh event restarts the hold count, so the hold runs from the last event
    always @* begin
        nxt_alarm = alarm_ff;
        nxt_hold_steps = hold_steps_ff;
        nxt_tick_cnt = tick_cnt_ff;
        case (alarm_ff)
            ALARM_OFF: begin
                if (any_alarm) begin
                    nxt_alarm = ALARM_ON;
                    nxt_hold_steps = alarm_hold_time; // [RULE_12]
                    nxt_tick_cnt = 32'h0;
                end
            end
            ALARM_ON: begin
                if (any_alarm) begin
                    nxt_hold_steps = alarm_hold_time; // [RULE_12]
                    nxt_tick_cnt = 32'h0;
                end else if (hold_done) begin
                    nxt_alarm = ALARM_OFF; // [RULE_15]
                end else if (tick) begin
                    nxt_hold_steps = hold_steps_ff - 3'h1; // [RULE_15]
                    nxt_tick_cnt = 32'h0;
                end else begin
                    nxt_tick_cnt = tick_cnt_ff + 32'h1;
                end
            end
            default: begin
                nxt_alarm = ALARM_OFF;
            end
        endcase
    end

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            alarm_ff <= ALARM_OFF;
            hold_steps_ff <= 3'h0;
            tick_cnt_ff <= 32'h0;
        end else begin
            alarm_ff <= nxt_alarm;
            hold_steps_ff <= nxt_hold_steps;
            tick_cnt_ff <= nxt_tick_cnt;
        end
    end

    //------------------------------------------------------------
    // alarm pin and outputs
    //------------------------------------------------------------
    // polarity 0: low on error; polarity 1: low without error
    reg want_low;
    always @* begin
        case (alarm_polarity_sel)
            1'b0: want_low = alarm_ff; // [RULE_08] [RULE_09]
            1'b1: want_low = ~alarm_ff; // [RULE_09]
            default: want_low = 1'b0;
        endcase
    end

    // the pin is only ever pulled low; released means high or pulled up
    assign alarm_pin_out = 1'b0;
    assign alarm_pin_oe_out = want_low & ~shutdown_ff; // [RULE_03] [RULE_11]
    assign alarm_pullup_en_out = log_mask_low_pullup_ff[`PULLUP_EN_BIT]; // [RULE_13]

    //------------------------------------------------------------
    // status outputs
    //------------------------------------------------------------
    assign driver_enable_out = ~shutdown_ff; // [RULE_03]
    assign aux_low_range_out = shutdown_ff; // [RULE_03]
    assign log_latch_out = log_latch_ff;
    assign event_out = event_ff;
    assign alarm_active_out = alarm_ff;

    //------------------------------------------------------------
    // register read
    //------------------------------------------------------------
    // unmapped addresses read as zero
    always @* begin
        case (reg_addr_in)
            `ALARM_EVENT_MASK_ADDR: nxt_reg_rdata = alarm_event_mask_ff;
            `ALARM_PIN_CONFIG_ADDR: nxt_reg_rdata = alarm_pin_config_ff;
            `SHUTDOWN_EVENT_MASK_ADDR: nxt_reg_rdata = shutdown_event_mask_ff;
            `LOG_MASK_LOW_PULLUP_ADDR: nxt_reg_rdata = log_mask_low_pullup_ff;
            `LOG_MASK_HIGH_ADDR: nxt_reg_rdata = log_mask_high_ff;
            default: nxt_reg_rdata = 8'h00;
        endcase
    end

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            reg_rdata_out <= nxt_reg_rdata;
        end
    end
endmodule

/* verif/error_mask_alarm_props.sv */
// assertion checker on the ports of the error mask and alarm block
module error_mask_alarm_props (
    input wire clk_in, input wire sys_rst_in, input wire overtemp_in,
    input wire clip_in, input wire loss_in, input wire excess_input_in,
    input wire alarm_pin_out, input wire alarm_pin_oe_out, input wire driver_enable_out,
    input wire aux_low_range_out, input wire [6:0] log_latch_out,
    input wire [6:0] event_out, input wire alarm_active_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_od; !alarm_pin_out; endproperty
    a_od: assert property (p_od) else $error("pin data high");
    property p_ls; loss_in | clip_in | excess_input_in |=> event_out[0]; endproperty
    a_ls: assert property (p_ls) else $error("loss event missing");
    property p_tw; overtemp_in |=> event_out[5]; endproperty
    a_tw: assert property (p_tw) else $error("temp event missing");
    property p_sd; driver_enable_out != aux_low_range_out; endproperty
    a_sd: assert property (p_sd) else $error("aux range mismatch");
    property p_so; !driver_enable_out |-> !alarm_pin_oe_out; endproperty
    a_so: assert property (p_so) else $error("pin driven in shutdown");
    property p_lk; ($past(log_latch_out) & ~log_latch_out) == 7'h00; endproperty
    a_lk: assert property (p_lk) else $error("log latch lost");
    property p_lc; (log_latch_out & ~$past(log_latch_out | event_out)) == 7'h00; endproperty
    a_lc: assert property (p_lc) else $error("log without event");
    property p_al; $rose(alarm_active_out) |-> $past(event_out) != 7'h00; endproperty
    a_al: assert property (p_al) else $error("alarm without event");
endmodule

bind error_mask_alarm error_mask_alarm_props error_mask_alarm_props_i (.*);

/* verif/alarm_observer.sv */
// far-side system on the alarm line, which a resistor pulls high when released
module alarm_observer (
    input wire dut_pull_low_in, input wire ext_err_in, output wire pin_level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pin_level_out = !(dut_pull_low_in | ext_err_in);
endmodule

/* verif/test_error_mask_alarm.sv */
// self-checking bench for the error mask and alarm block
module test_error_mask_alarm;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 0, rst = 1, wr_en = 0, chk = 0, ext = 0, oe, pu, drv, aux, lvl;
    logic [7:0] addr = 8'h00, wd = 8'h00, src = 8'h00, rd, d;
    logic [6:0] lat, ev;
    int qs[$];
    logic [7:0] qv[$];
    int n_mismatch = 0, comparisons = 0;
    error_mask_alarm #(.HOLD_STEP_CYCLES(4)) error_mask_alarm_i (.clk_in(clk_in),
        .sys_rst_in(rst), .reg_wr_in(wr_en), .reg_addr_in(addr), .reg_wdata_in(wd),
        .reg_rdata_out(rd), .config_err_in(src[7]), .overtemp_in(src[6]),
        .ctrl_max_in(src[5]), .ctrl_min_in(src[4]), .clip_in(src[3]), .loss_in(src[2]),
        .excess_input_in(src[1]), .config_err_stored_in(src[0]), .alarm_pin_in(lvl),
        .alarm_pin_out(), .alarm_pin_oe_out(oe), .alarm_pullup_en_out(pu),
        .driver_enable_out(drv), .aux_low_range_out(aux), .log_latch_out(lat),
        .event_out(ev), .alarm_active_out());
    alarm_observer alarm_observer_i (.dut_pull_low_in(oe), .ext_err_in(ext),
        .pin_level_out(lvl));
    initial forever #2 clk_in = !clk_in;
    task automatic step(input int n); repeat (n) @(negedge clk_in); endtask
    task automatic wr(input [7:0] a, input [7:0] v);
        wr_en = 1;
        addr = a;
        wd = v;
        step(1);
    endtask
    // note the expectation, the watcher compares it at the next rising edge
    task automatic sc(input [7:0] s, input int n, input int sel, input [7:0] v);
        wr_en = 0;
        src = s;
        step(n);
        qs.push_back(sel);
        qv.push_back(v);
        chk = 1;
        @(posedge clk_in);
        chk <= 0;
        @(negedge clk_in);
    endtask
    function automatic logic [7:0] pick(input int s);
        case (s)
            0: return rd;
            1: return {7'h00, oe};
            2: return {6'h00, aux, drv};
            3: return {1'b0, ev};
            4: return {1'b0, lat};
            default: return {7'h00, pu};
        endcase
    endfunction
    task automatic check(input [7:0] seen, input [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    always @(posedge clk_in) if (chk) check(pick(qs.pop_front()), qv.pop_front());
    task automatic report_and_stop;
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #5000;
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        void'($urandom(32'h5224e543));
        step(5);
        rst = 0;
        for (int a = 'h54; a < 'h5a; a++) begin
            d = $urandom;
            wr(a[7:0], d);
            addr = a[7:0];
            sc(8'h00, 1, 0, a == 'h59 ? 8'h00 : d);
        end
        rst = 1;
        addr = 8'h54;
        step(2);
        rst = 0;
        sc(8'h00, 1, 0, 8'h00);
        wr(8'h54, 8'h01);
        wr(8'h55, 8'h10);
        sc(8'h40, 3, 1, 8'h00);
        sc(8'h08, 3, 1, 8'h01);
        sc(8'h00, 5, 1, 8'h01);
        sc(8'h00, 16, 1, 8'h00);
        ext = 1;
        sc(8'h00, 3, 3, 8'h10);
        wr(8'h55, 8'h04);
        sc(8'h00, 3, 3, 8'h00);
        sc(8'h00, 0, 1, 8'h01);
        ext = 0;
        sc(8'h04, 3, 1, 8'h00);
        wr(8'h55, 8'h00);
        wr(8'h54, 8'h08);
        wr(8'h56, 8'h08);
        sc(8'h20, 3, 2, 8'h02);
        sc(8'h20, 0, 1, 8'h00);
        sc(8'h00, 3, 2, 8'h01);
        wr(8'h58, 8'h40);
        sc(8'h20, 3, 2, 8'h02);
        sc(8'h00, 3, 2, 8'h02);
        rst = 1;
        step(2);
        rst = 0;
        wr(8'h57, 8'h14);
        wr(8'h58, 8'h04);
        sc(8'hc2, 3, 2, 8'h01);
        sc(8'h00, 2, 4, 8'h41);
        sc(8'h00, 0, 5, 8'h01);
        wr(8'h56, 8'h40);
        sc(8'h01, 3, 2, 8'h02);
        sc(8'h10, 3, 3, 8'h04);
        report_and_stop;
    end
endmodule
